// ==== hdl/csh_pkg.sv ====
// Constants, register map and helpers shared by the serial host controller and its testbench.
package csh_pkg;

   ////////////////////////////////////////////////////////////////////////////
   localparam int CLK_MHZ = 25;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CAN_MHZ = 24;

   localparam int CS_TO_CLK_NS = 84;
   localparam int READ_GAP_NS = 584;
   localparam int WRITE_GAP_NS = 209;
   localparam int TAIL_NS = 459;
   localparam int DESEL_NS = 167;

   localparam int CS_TO_CLK_CYC = (CS_TO_CLK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_GAP_CYC = (READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_GAP_CYC = (WRITE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TAIL_CYC = (TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DESEL_CYC = (DESEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Device reset and post-reset wait are given in device clock cycles.
   localparam int RST_MIN_CAN_CYC = 5;
   localparam int POST_RST_CAN_CYC = 1100;
   localparam int RST_MIN_CYC = (RST_MIN_CAN_CYC * CLK_MHZ + CAN_MHZ - 1) / CAN_MHZ;
   localparam int POST_RST_CYC = (POST_RST_CAN_CYC * CLK_MHZ + CAN_MHZ - 1) / CAN_MHZ;
   localparam int SOFT_RST_CYC = 128;

   // Serial clock may not exceed a quarter of the device clock.
   localparam int SCLK_DEV_DIV = 4;
   localparam int HALF_MIN_CYC = (SCLK_DEV_DIV * CLK_MHZ + 2 * CAN_MHZ - 1) / (2 * CAN_MHZ);

   localparam int POST_DLY_UNIT = 32;

   ////////////////////////////////////////////////////////////////////////////
   localparam logic [6:0] CLK_DLY_RST = 7'h06;
   localparam logic [7:0] POST_DLY_RST = 8'h02;
   localparam logic [7:0] BAUD_RST = 8'h06;

   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_RESET = 8'h04;
   localparam logic [7:0] OFS_TIMING = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [1:0] OFS_BUF_PAGE = 2'h1;

   localparam int CMD_ADDR_LSB = 0;
   localparam int CMD_CNT_LSB = 8;
   localparam int CMD_RD_BIT = 12;
   localparam int CMD_GO_BIT = 13;
   localparam int RST_SOFT_BIT = 0;
   localparam int RST_LONG_BIT = 1;
   localparam int TIM_CLK_DLY_LSB = 0;
   localparam int TIM_POST_DLY_LSB = 8;
   localparam int TIM_BAUD_LSB = 16;
   localparam int TIM_EVEN_CLK_BIT = 24;
   localparam logic WR_FLAG = 1'b1;

   localparam int BUF_DEPTH = 16;

   function automatic logic [15:0] csh_max(input logic [15:0] a, input logic [15:0] b);
      csh_max = (a > b) ? a : b;
   endfunction

endpackage

// ==== hdl/csh_byte_if.sv ====
// Byte transfer handshake between the access sequencer and the serial shifter.
`timescale 1ns/1ps
interface csh_byte_if;
   logic start;
   logic [7:0] tx;
   logic [7:0] half;
   logic miso_s;
   logic busy;
   logic done;
   logic [7:0] rx;
   logic sclk;
   logic mosi;
   modport seq (output start, output tx, output half, output miso_s,
                input busy, input done, input rx, input sclk, input mosi);
   modport shf (input start, input tx, input half, input miso_s,
                output busy, output done, output rx, output sclk, output mosi);
endinterface

// ==== hdl/csh_shifter.sv ====
// Serial byte shifter: clock idles high, data changes on the falling edge, sampled on the rising edge.
`timescale 1ns/1ps
module csh_shifter (
   input wire logic clk_i,
   input wire logic srst_i,
   csh_byte_if.shf bif
);

   logic busy, next_busy;
   logic done, next_done;
   logic sclk, next_sclk;
   logic mosi, next_mosi;
   logic [7:0] sh, next_sh;
   logic [7:0] rx, next_rx;
   logic [7:0] cnt, next_cnt;
   logic [2:0] bit_idx, next_bit_idx;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_busy = busy;
      next_done = 1'b0;
      next_sclk = sclk;
      next_mosi = mosi;
      next_sh = sh;
      next_rx = rx;
      next_cnt = cnt;
      next_bit_idx = bit_idx;
      if (!busy) begin
         if (bif.start) begin
            next_busy = 1'b1;
            next_sclk = 1'b0;
            next_mosi = bif.tx[7];
            next_sh = bif.tx;
            next_cnt = bif.half - 8'h01;
            next_bit_idx = 3'h7;
         end
      end else if (cnt != 8'h00) begin
         next_cnt = cnt - 8'h01;
      end else if (!sclk) begin
         next_sclk = 1'b1;
         next_sh = {sh[6:0], bif.miso_s};
         next_cnt = bif.half - 8'h01;
         if (bit_idx == 3'h0) begin
            next_busy = 1'b0;
            next_done = 1'b1;
            next_rx = {sh[6:0], bif.miso_s};
         end
      end else begin
         next_sclk = 1'b0;
         next_mosi = sh[7];
         next_bit_idx = bit_idx - 3'h1;
         next_cnt = bif.half - 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         busy <= 1'b0;
         done <= 1'b0;
         sclk <= 1'b1;
         mosi <= 1'b0;
         sh <= 8'h00;
         rx <= 8'h00;
         cnt <= 8'h00;
         bit_idx <= 3'h0;
      end else begin
         busy <= next_busy;
         done <= next_done;
         sclk <= next_sclk;
         mosi <= next_mosi;
         sh <= next_sh;
         rx <= next_rx;
         cnt <= next_cnt;
         bit_idx <= next_bit_idx;
      end
   end

   assign bif.busy = busy;
   assign bif.done = done;
   assign bif.rx = rx;
   assign bif.sclk = sclk;
   assign bif.mosi = mosi;

endmodule

// ==== hdl/csh_host.sv ====
// Host controller that resets a standalone CAN controller and runs timed serial register accesses to it.
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps

// How it works
// - Address byte first, then data at rising addresses.
// - Select stays low until the access ends.
// - Select-to-first-clock wait at least 84 ns.
// - Read byte gaps at least 584 ns.
// - Write byte gaps at least 209 ns.
// - Last byte to deselect at least 459 ns.
// - Select high at least 167 ns between accesses.
// - Clock delay is count clocks, 1 to 127.
// - Byte delay is 32 times count, 1-255.
// - Default counts six and two.
// - Serial clock at most quarter device clock.
// - Serial rate is clock over twice divider.
// - Device reset held at least five device clocks.
// - No access for 1100 device clocks after reset.
// - Reset pulse 128 soft, 32K full clocks.
// - Address byte msb selects read or write.
// - MSB first, idle high, shift leading edge.
module csh_host #(
   parameter int LONG_RST_CYC = 32768
) (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rd_data_o,
   output logic cs_n_o,
   output logic sclk_o,
   output logic mosi_o,
   input wire logic miso_i,
   output logic host_reset_output_n_o,
   input wire logic irq_pin_even_n_i,
   input wire logic irq_pin_odd_n_i
);

   typedef enum {ST_RST_LOW, ST_RST_WAIT, ST_IDLE, ST_SEL, ST_SHIFT, ST_GAP, ST_TAIL, ST_DESEL} csh_state_e;

   csh_byte_if bif ();

   csh_state_e state, next_state;
   logic [15:0] tmr, next_tmr;
   logic cs_n, next_cs_n;
   logic rst_n, next_rst_n;
   logic start, next_start;
   logic [7:0] tx, next_tx;
   logic [6:0] reg_addr, next_reg_addr;
   logic rd_q, next_rd_q;
   logic [3:0] nbytes, next_nbytes;
   logic [4:0] idx, next_idx;
   logic [6:0] clk_dly, next_clk_dly;
   logic [7:0] post_dly, next_post_dly;
   logic [7:0] baud, next_baud;
   logic even_clk, next_even_clk;
   logic [31:0] rd_data, next_rd_data;
   logic [7:0] buf_mem [csh_pkg::BUF_DEPTH];
   logic [7:0] next_buf_mem [csh_pkg::BUF_DEPTH];
   logic [1:0] miso_ff, even_ff, odd_ff;
   logic [15:0] post_cyc;
   logic [3:0] buf_wr_idx;

   ////////////////////////////////////////////////////////////////////////////
   // Pins from the device pass two flops; only the second is read.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         miso_ff <= 2'h0;
         even_ff <= 2'h3;
         odd_ff <= 2'h3;
      end else begin
         miso_ff <= {miso_ff[0], miso_i};
         even_ff <= {even_ff[0], irq_pin_even_n_i};
         odd_ff <= {odd_ff[0], irq_pin_odd_n_i};
      end
   end

   // Baud below the floor is raised, so software cannot overrun the device.
   assign bif.half = csh_pkg::csh_max({8'h00, baud}, 16'(csh_pkg::HALF_MIN_CYC)) > 16'h00ff ? 8'hff :
                     8'(csh_pkg::csh_max({8'h00, baud}, 16'(csh_pkg::HALF_MIN_CYC)));
   assign bif.miso_s = miso_ff[1];
   assign bif.start = start;
   assign bif.tx = tx;
   assign post_cyc = 16'(post_dly) * 16'(csh_pkg::POST_DLY_UNIT);

   csh_shifter u_shifter (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .bif(bif)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      next_tmr = (tmr != 16'h0000) ? tmr - 16'h0001 : tmr;
      next_cs_n = cs_n;
      next_rst_n = rst_n;
      next_start = 1'b0;
      next_tx = tx;
      next_reg_addr = reg_addr;
      next_rd_q = rd_q;
      next_nbytes = nbytes;
      next_idx = idx;
      next_clk_dly = clk_dly;
      next_post_dly = post_dly;
      next_baud = baud;
      next_even_clk = even_clk;
      next_buf_mem = buf_mem;
      buf_wr_idx = 4'(idx - 5'h01);
      if (wr_i && addr_i == csh_pkg::OFS_TIMING) begin
         next_clk_dly = wr_data_i[csh_pkg::TIM_CLK_DLY_LSB +: 7];
         next_post_dly = wr_data_i[csh_pkg::TIM_POST_DLY_LSB +: 8];
         next_baud = wr_data_i[csh_pkg::TIM_BAUD_LSB +: 8];
         next_even_clk = wr_data_i[csh_pkg::TIM_EVEN_CLK_BIT];
      end
      if (wr_i && addr_i[7:6] == csh_pkg::OFS_BUF_PAGE) begin
         next_buf_mem[addr_i[5:2]] = wr_data_i[7:0];
      end
      case (state)
         ST_RST_LOW: begin
            if (tmr == 16'h0000) begin
               next_rst_n = 1'b1;
               next_tmr = 16'(csh_pkg::POST_RST_CYC - 1);
               next_state = ST_RST_WAIT;
            end
         end
         ST_RST_WAIT: begin
            if (tmr == 16'h0000) begin
               next_state = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (wr_i && addr_i == csh_pkg::OFS_RESET && (wr_data_i[csh_pkg::RST_SOFT_BIT] ||
                wr_data_i[csh_pkg::RST_LONG_BIT])) begin
               next_rst_n = 1'b0;
               next_tmr = wr_data_i[csh_pkg::RST_LONG_BIT] ? 16'(LONG_RST_CYC - 1) :
                          16'(csh_pkg::SOFT_RST_CYC - 1);
               next_state = ST_RST_LOW;
            end else if (wr_i && addr_i == csh_pkg::OFS_CMD && wr_data_i[csh_pkg::CMD_GO_BIT]) begin
               next_cs_n = 1'b0;
               next_reg_addr = wr_data_i[csh_pkg::CMD_ADDR_LSB +: 7];
               next_nbytes = wr_data_i[csh_pkg::CMD_CNT_LSB +: 4];
               next_rd_q = wr_data_i[csh_pkg::CMD_RD_BIT];
               next_idx = 5'h00;
               next_tmr = csh_pkg::csh_max({9'h000, clk_dly}, 16'(csh_pkg::CS_TO_CLK_CYC)) - 16'h0001;
               next_state = ST_SEL;
            end
         end
         ST_SEL, ST_GAP: begin
            if (tmr == 16'h0000) begin
               next_start = 1'b1;
               next_tx = (idx == 5'h00) ? {rd_q ? ~csh_pkg::WR_FLAG : csh_pkg::WR_FLAG, reg_addr} :
                         buf_mem[buf_wr_idx];
               next_state = ST_SHIFT;
            end
         end
         ST_SHIFT: begin
            if (bif.done) begin
               if (rd_q && idx != 5'h00) begin
                  next_buf_mem[buf_wr_idx] = bif.rx;
               end
               if (idx == {1'b0, nbytes} + 5'h01) begin
                  next_tmr = csh_pkg::csh_max(post_cyc, 16'(csh_pkg::TAIL_CYC)) - 16'h0001;
                  next_state = ST_TAIL;
               end else begin
                  next_idx = idx + 5'h01;
                  next_tmr = csh_pkg::csh_max(post_cyc, rd_q ? 16'(csh_pkg::READ_GAP_CYC) :
                             16'(csh_pkg::WRITE_GAP_CYC)) - 16'h0001;
                  next_state = ST_GAP;
               end
            end
         end
         ST_TAIL: begin
            if (tmr == 16'h0000) begin
               next_cs_n = 1'b1;
               next_tmr = csh_pkg::csh_max(post_cyc, 16'(csh_pkg::DESEL_CYC)) - 16'h0001;
               next_state = ST_DESEL;
            end
         end
         ST_DESEL: begin
            if (tmr == 16'h0000) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Transfer length comes from each command's count field, one to sixteen data bytes; the trade is one access per command.
   always_comb begin
      next_rd_data = 32'h0000_0000;
      if (rd_i) begin
         if (addr_i == csh_pkg::OFS_TIMING) begin
            next_rd_data = {7'h00, even_clk, baud, post_dly, 1'b0, clk_dly};
         end else if (addr_i == csh_pkg::OFS_STATUS) begin
            // The even pin carries no request while it is used as a clock.
            next_rd_data = {26'h0, odd_ff[1] == 1'b0, even_ff[1] == 1'b0 && !even_clk, even_clk,
                            state == ST_RST_WAIT, state == ST_RST_LOW, state != ST_IDLE};
         end else if (addr_i[7:6] == csh_pkg::OFS_BUF_PAGE) begin
            next_rd_data = {24'h0, buf_mem[addr_i[5:2]]};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= ST_RST_LOW;
         tmr <= 16'(LONG_RST_CYC - 1);
         cs_n <= 1'b1;
         rst_n <= 1'b0;
         start <= 1'b0;
         tx <= 8'h00;
         reg_addr <= 7'h00;
         rd_q <= 1'b0;
         nbytes <= 4'h0;
         idx <= 5'h00;
         clk_dly <= csh_pkg::CLK_DLY_RST;
         post_dly <= csh_pkg::POST_DLY_RST;
         baud <= csh_pkg::BAUD_RST;
         even_clk <= 1'b0;
         rd_data <= 32'h0000_0000;
         for (int i = 0; i < csh_pkg::BUF_DEPTH; i++) begin
            buf_mem[i] <= 8'h00;
         end
      end else begin
         state <= next_state;
         tmr <= next_tmr;
         cs_n <= next_cs_n;
         rst_n <= next_rst_n;
         start <= next_start;
         tx <= next_tx;
         reg_addr <= next_reg_addr;
         rd_q <= next_rd_q;
         nbytes <= next_nbytes;
         idx <= next_idx;
         clk_dly <= next_clk_dly;
         post_dly <= next_post_dly;
         baud <= next_baud;
         even_clk <= next_even_clk;
         rd_data <= next_rd_data;
         buf_mem <= next_buf_mem;
      end
   end

   assign rd_data_o = rd_data;
   assign cs_n_o = cs_n;
   assign sclk_o = bif.sclk;
   assign mosi_o = bif.mosi;
   assign host_reset_output_n_o = rst_n;

   ////////////////////////////////////////////////////////////////////////////
   // Helper counters watched only by the checks below.
   logic [15:0] hi_cnt, low_cnt;
   logic [11:0] since_rst;
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         hi_cnt <= 16'h0000;
         low_cnt <= 16'h0000;
         since_rst <= 12'h000;
      end else begin
         hi_cnt <= !bif.sclk ? 16'h0000 : (hi_cnt == 16'hffff ? hi_cnt : hi_cnt + 16'h0001);
         low_cnt <= rst_n ? 16'h0000 : low_cnt + 16'h0001;
         since_rst <= !rst_n ? 12'h000 : (since_rst == 12'hfff ? since_rst : since_rst + 12'h001);
      end
   end

   property p_cs_to_clk;
      @(posedge clk_i) disable iff (srst_i) $fell(cs_n_o) |-> sclk_o [*3];
   endproperty
   a_cs_to_clk: assert property (p_cs_to_clk) else $error("serial clock too soon after select");

   property p_desel_gap;
      @(posedge clk_i) disable iff (srst_i) $rose(cs_n_o) |-> cs_n_o [*5];
   endproperty
   a_desel_gap: assert property (p_desel_gap) else $error("select reasserted too soon");

   property p_half_period;
      @(posedge clk_i) disable iff (srst_i) $fell(sclk_o) |-> !sclk_o [*3];
   endproperty
   a_half_period: assert property (p_half_period) else $error("serial clock low phase too short");

   property p_rst_min;
      @(posedge clk_i) disable iff (srst_i) $fell(host_reset_output_n_o) |-> !host_reset_output_n_o [*6];
   endproperty
   a_rst_min: assert property (p_rst_min) else $error("device reset pulse too short");

   property p_rst_len;
      @(posedge clk_i) disable iff (srst_i) $rose(host_reset_output_n_o) |->
         (low_cnt == 16'(csh_pkg::SOFT_RST_CYC) || low_cnt == 16'(LONG_RST_CYC));
   endproperty
   a_rst_len: assert property (p_rst_len) else $error("reset pulse neither soft nor full length");

   property p_post_rst;
      @(posedge clk_i) disable iff (srst_i) $fell(cs_n_o) |-> since_rst >= 12'(csh_pkg::POST_RST_CYC);
   endproperty
   a_post_rst: assert property (p_post_rst) else $error("access started too soon after reset");

   property p_byte_gap;
      @(posedge clk_i) disable iff (srst_i) (bif.start && idx != 5'h00) |->
         hi_cnt >= (rd_q ? 16'(csh_pkg::READ_GAP_CYC) : 16'(csh_pkg::WRITE_GAP_CYC));
   endproperty
   a_byte_gap: assert property (p_byte_gap) else $error("gap between bytes too short");

   property p_tail;
      @(posedge clk_i) disable iff (srst_i) $rose(cs_n_o) |-> hi_cnt >= 16'(csh_pkg::TAIL_CYC);
   endproperty
   a_tail: assert property (p_tail) else $error("deselect too soon after last byte");

   property p_whole_access;
      @(posedge clk_i) disable iff (srst_i) $rose(cs_n_o) |-> $past(idx) == {1'b0, $past(nbytes)} + 5'h01;
   endproperty
   a_whole_access: assert property (p_whole_access) else $error("select released mid access");

   property p_addr_flag;
      @(posedge clk_i) disable iff (srst_i) (bif.start && idx == 5'h00) |-> bif.tx[7] == !rd_q;
   endproperty
   a_addr_flag: assert property (p_addr_flag) else $error("address byte direction bit wrong");

   // A start while the shifter is busy would be ignored, so its byte would never be sent.
   property p_start_free;
      @(posedge clk_i) disable iff (srst_i) bif.start |-> !bif.busy;
   endproperty
   a_start_free: assert property (p_start_free) else $error("byte started while shifter busy");

   c_read: cover property (@(posedge clk_i) disable iff (srst_i) $rose(cs_n_o) && rd_q);
   c_write: cover property (@(posedge clk_i) disable iff (srst_i) $rose(cs_n_o) && !rd_q);
   c_soft_rst: cover property (@(posedge clk_i) disable iff (srst_i) $rose(host_reset_output_n_o) &&
                               low_cnt == 16'(csh_pkg::SOFT_RST_CYC));

endmodule

// ==== test/csh_dev_model.sv ====
// Behavioural CAN controller serial slave that times every host access.
`timescale 1ns/1ps
module csh_dev_model (
   input wire logic rst_n_i,
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic mosi_i,
   output logic miso_o,
   input wire logic req_even_i,
   input wire logic req_odd_i,
   output logic irq_even_n_o,
   output logic irq_odd_n_o,
   output int err_o
);
   // Device clock period; a slip below any limit counts as a fault.
   localparam real TD = 1000.0 / 24.0;
   logic [7:0] regs [128];
   logic [7:0] sh;
   logic [7:0] tx;
   logic [6:0] a;
   logic wr = 1'b0;
   logic fst = 1'b0;
   int nb = 0;
   int nby = 0;
   realtime t_rf = 0, t_rr = 0, t_cf = 0, t_cr = 0, t_r = 0, t_e = 0;
   task automatic ok(input bit c);
      if (!c) err_o++;
   endtask
   initial begin
      err_o = 0;
      miso_o = 1'b0;
      for (int i = 0; i < 128; i++) regs[i] = 8'(i) ^ 8'h5a;
   end
   //////////////////////////////////////////////////////////////
   // Only message object 0 and the first node request are driven; all other sources stay quiet.
   logic [71:0] src;
   logic [71:0] src_mask = {72{1'b1}};
   logic [7:0] node_req;
   assign src = {7'h00, req_odd_i, 63'h0, req_even_i};
   assign node_req = {6'h00, |(src[71:64] & src_mask[71:64]), |(src[63:0] & src_mask[63:0])};
   assign irq_even_n_o = ~|{node_req[6], node_req[4], node_req[2], node_req[0]};
   assign irq_odd_n_o = ~|{node_req[7], node_req[5], node_req[3], node_req[1]};
   always @(negedge rst_n_i) t_rf = $realtime;
   always @(posedge rst_n_i) begin
      ok($realtime - t_rf >= 5 * TD);
      t_rr = $realtime;
   end
   always @(negedge cs_n_i) begin
      ok(rst_n_i === 1'b1 && $realtime - t_rr >= 1100 * TD);
      ok($realtime - t_cr >= 167 && sclk_i === 1'b1);
      t_cf = $realtime;
      nb = 0;
      nby = 0;
      fst = 1'b1;
   end
   // A released data line shows the inverse so a stale value never passes.
   always @(posedge cs_n_i) begin
      if (nby > 0) ok($realtime - t_r >= 459 && nb == 0);
      t_cr = $realtime;
      miso_o = ~miso_o;
   end
   always @(negedge sclk_i) if (!cs_n_i) begin
      if (fst) ok($realtime - t_cf >= 84);
      else if (nb == 0) ok($realtime - t_r >= (wr ? 209 : 584));
      else ok($realtime - t_e >= 2 * TD);
      fst = 1'b0;
      t_e = $realtime;
      if (nby > 0 && !wr) begin
         miso_o = tx[7];
         tx = tx << 1;
      end
   end
   always @(posedge sclk_i) if (!cs_n_i) begin
      ok($realtime - t_e >= 2 * TD);
      t_e = $realtime;
      t_r = $realtime;
      sh = {sh[6:0], mosi_i};
      nb++;
      if (nb == 8) begin
         nb = 0;
         if (nby == 0) begin
            wr = sh[7];
            a = sh[6:0];
         end else begin
            if (wr) regs[a] = sh;
            a++;
         end
         tx = regs[a];
         nby++;
      end
   end
endmodule

// ==== test/csh_host_tb.sv ====
// Self-checking bench for the serial host controller against a timed device model.
`timescale 1ns/1ps
module csh_host_tb;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic re = 1'b0;
   logic ro = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wr_data_i = 32'h0;
   logic [31:0] rd_data_o;
   logic [31:0] rdv;
   logic cs_n, sclk, mosi, miso, rst_n, ev_n, od_n;
   logic [11:0] tbl = 12'b000_111_010_001;
   int err;
   int n_fail = 0;
   int samples_checked = 0;
   csh_host #(.LONG_RST_CYC(64)) csh_host_i (
      .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
      .rd_data_o(rd_data_o), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi), .miso_i(miso),
      .host_reset_output_n_o(rst_n), .irq_pin_even_n_i(ev_n), .irq_pin_odd_n_i(od_n));
   csh_dev_model csh_dev_model_i (
      .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk), .mosi_i(mosi), .miso_o(miso), .req_even_i(re),
      .req_odd_i(ro), .irq_even_n_o(ev_n), .irq_odd_n_o(od_n), .err_o(err));
   initial forever #20 clk_i = ~clk_i;
   //////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic end_sim;
      $display("mismatches %0d, comparisons %0d", n_fail, samples_checked);
      if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 rdv = rd_data_o;
   endtask
   task automatic idle;
      int i;
      i = 0;
      do begin
         rd(csh_pkg::OFS_STATUS);
         i++;
      end while (rdv[2:0] !== 3'h0 && i < 4000);
      if (i >= 4000) begin
         n_fail++;
         end_sim;
      end
   endtask
   task automatic go(input logic [6:0] a, input logic [3:0] c, input logic r);
      wr(csh_pkg::OFS_CMD, {18'h0, 1'b1, r, c, 1'b0, a});
      idle;
   endtask
   // Bytes 0x10..0x1f are the ones t_write writes; 0x05 and 0x06 are written later, the rest keep the preload.
   function automatic logic [7:0] ex(input int a);
      ex = (a >= 16 && a < 32) ? 8'(a + 145) : 8'(a) ^ 8'h5a;
   endfunction
   //////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk(rst_n, 1'b0);
      rd(csh_pkg::OFS_TIMING);
      chk(rdv, 32'h00060206);
      @(posedge clk_i);
      #1 chk(rd_data_o, 32'h0);
      rd(csh_pkg::OFS_STATUS);
      chk(rdv[1], 1'b1);
      rd(8'h20);
      chk(rdv, 32'h0);
      wr(csh_pkg::OFS_CMD, 32'h2010);
      idle;
   endtask
   task automatic t_write;
      for (int i = 0; i < 16; i++) wr(8'h40 + 8'(4 * i), 32'(ex(16 + i)));
      go(7'h10, 4'hf, 1'b0);
      for (int i = 0; i < 16; i++) chk(csh_dev_model_i.regs[16 + i], ex(16 + i));
   endtask
   task automatic t_read;
      go(7'h1e, 4'h3, 1'b1);
      for (int i = 0; i < 4; i++) begin
         rd(8'h40 + 8'(4 * i));
         chk(rdv[7:0], ex(30 + i));
      end
   endtask
   task automatic t_fast;
      wr(csh_pkg::OFS_TIMING, 32'h00010101);
      rd(csh_pkg::OFS_TIMING);
      chk(rdv, 32'h00010101);
      go(7'h11, 4'h0, 1'b1);
      rd(8'h40);
      chk(rdv[7:0], ex(17));
      go(7'h05, 4'h1, 1'b0);
      chk(csh_dev_model_i.regs[5], ex(17));
      chk(csh_dev_model_i.regs[6], ex(31));
   endtask
   task automatic t_irq;
      logic [2:0] m;
      for (int k = 0; k < 4; k++) begin
         m = tbl[3 * k +: 3];
         wr(csh_pkg::OFS_TIMING, {7'h0, m[2], 24'h020206});
         re <= m[0];
         ro <= m[1];
         repeat (3) @(posedge clk_i);
         rd(csh_pkg::OFS_STATUS);
         chk(rdv[5:3], {m[1], m[0] & ~m[2], m[2]});
      end
   endtask
   task automatic t_pulse;
      int n;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         wr(csh_pkg::OFS_RESET, 32'(k + 1));
         repeat (200) begin
            #1 n += int'(rst_n === 1'b0);
            @(posedge clk_i);
         end
         chk(n, k ? 64 : 128);
         rd(csh_pkg::OFS_STATUS);
         chk(rdv[2], 1'b1);
         go(7'h10, 4'h0, 1'b1);
      end
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      @(posedge clk_i);
      #1 t_reset;
      t_write;
      t_read;
      t_fast;
      t_irq;
      t_pulse;
      chk(err, 0);
      end_sim;
   end
endmodule
